// >>> dv/tb_thermal_power_limit_control.sv
`timescale 1ns/1ps
module tb_thermal_power_limit_control;
  import tpl_pkg::*;
  localparam logic [7:0] TMAX = 8'h28;
  logic clk, rstn, rd, wr, ack, thermal_control_circuit, hot, lim, slow;
  logic [11:0] addr;
  logic [63:0] wdata, rdata, rv;
  logic [3:0][7:0] sens;
  logic [15:0] ppw, rest, plpw;
  logic [7:0] cr, gr, r0;
  tpl_pkg_cfg_t pc;
  tpl_plat_cfg_t pl;
  int n_errors, cmp_count, cyc;

  tpl_thermal_power_ctl #(.P_MAX_JUNCTION_TEMP(TMAX)) i_dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_rd(rd),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .i_on_die_temp_sensor(sens), .i_pkg_power(ppw),
    .i_plat_power(plpw), .i_pkg_cfg(pc), .i_plat_cfg(pl),
    .i_max_core_ratio(8'h20), .i_max_gfx_ratio(8'h1c), .o_core_ratio(cr),
    .o_gfx_ratio(gr), .o_thermal_control_circuit(thermal_control_circuit),
    .o_processor_hot_pin(hot), .o_power_limited(lim));
  tpl_reg_model i_reg (.i_core_clk(clk), .i_rstn(rstn), .i_slow(slow),
    .i_cpu_pw(ppw), .i_rest_pw(rest), .o_plat_power(plpw));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run needs about 11300 cycles; over three times that means a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic reg_acc(input logic w, input logic [11:0] a,
                         input logic [63:0] d);
    @(negedge clk);
    rd = !w;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    chk("ack", 64'h1, ack);
    rv = rdata;
  endtask

  task automatic t_reset;
    reg_acc(1'b0, 12'h1a2, 64'h0);
    chk("reset read", {40'h0, TMAX, 16'h0}, rv);
    chk("ratios", 64'h0808, {cr, gr});
    chk("flags", 64'h0, {thermal_control_circuit, hot, lim});
    $display("test reset done");
  endtask
  task automatic t_regs;
    reg_acc(1'b1, 12'h1a2, 64'hffff_ffff_ffff_ffff);
    reg_acc(1'b0, 12'h1a2, 64'h0);
    chk("fields", {34'h0, 6'h3f, TMAX, 9'h0, 7'h7f}, rv);
    reg_acc(1'b1, 12'h1a3, 64'h0);
    reg_acc(1'b0, 12'h1a3, 64'h0);
    chk("unmapped read", 64'h0, rv);
    reg_acc(1'b0, 12'h1a2, 64'h0);
    chk("unmapped write", {34'h0, 6'h3f, TMAX, 9'h0, 7'h7f}, rv);
    wait_cyc(90);
    chk("saturated set point", 64'h1, thermal_control_circuit);
    reg_acc(1'b1, 12'h1a2, 64'h0);
    $display("test registers done");
  endtask
  task automatic t_sensor_max;
    wait_cyc(1100);
    chk("ceilings", 64'h201c, {cr, gr});
    sens[2] = 8'h00;
    wait_cyc(90);
    chk("control and hot", 64'h3, {thermal_control_circuit, hot});
    r0 = cr;
    wait_cyc(40);
    chk("core step", r0 - 8'h04, cr);
    wait_cyc(240);
    chk("floor", 64'h0808, {cr, gr});
    sens[2] = 8'h20;
    wait_cyc(90);
    chk("released", 64'h0, {thermal_control_circuit, hot});
    $display("test sensor max done");
  endtask
  task automatic t_offset;
    reg_acc(1'b1, 12'h1a2, 64'h0a00_0000);
    sens[0] = 8'h0a;
    wait_cyc(90);
    chk("at set point", 64'h1, thermal_control_circuit);
    sens[0] = 8'h0b;
    wait_cyc(90);
    chk("below set point", 64'h0, thermal_control_circuit);
    reg_acc(1'b1, 12'h1a2, 64'h0a00_0005);
    sens[0] = 8'h0a;
    wait_cyc(90);
    chk("averaged", 64'h0, thermal_control_circuit);
    sens[0] = 8'h00;
    wait_cyc(90);
    chk("max with offset", 64'h1, thermal_control_circuit);
    sens[0] = 8'h20;
    reg_acc(1'b1, 12'h1a2, 64'h0);
    $display("test offset done");
  endtask
  // Each case starts from full ratio so a step of 4 or 1 is visible.
  task automatic pw_base;
    pc = '{16'hffff, 16'hffff, 16'h0010, 16'hffff, 1'b0, 4'h0};
    pl = '{1'b0, 16'h0010, 16'h0010, 16'h0010, 1'b0, 4'h0};
    wait_cyc(1100);
  endtask
  task automatic pw_case(input logic e, input logic [7:0] st);
    wait_cyc(160);
    chk("limited", {63'h0, e}, lim);
    r0 = cr;
    wait_cyc(40);
    chk("ratio step", r0 - st, cr);
  endtask
  task automatic t_power;
    ppw = 16'h0032;
    rest = 16'h01f4;
    pw_base;
    pw_case(1'b0, 8'h00);
    pw_base;
    pc.burst_power_cap = 16'h0028;
    pw_case(1'b1, 8'h04);
    pw_base;
    pc.absolute_power_ceiling = 16'h0038;
    pw_case(1'b0, 8'h00);
    pc.absolute_power_ceiling = 16'h0037;
    pw_case(1'b1, 8'h04);
    pw_base;
    pc.spike_duty_en = 1'b1;
    pw_case(1'b1, 8'h04);
    pw_base;
    pc.sustained_power_cap = 16'h0028;
    pw_case(1'b1, 8'h01);
    pw_base;
    pl.plat_en = 1'b1;
    pw_case(1'b1, 8'h04);
    pw_base;
    slow = 1'b1;
    pc.tau_shift = 4'hf;
    pl = '{1'b1, 16'h0064, 16'hffff, 16'hffff, 1'b0, 4'h0};
    pw_case(1'b1, 8'h01);
    $display("test power done");
  endtask

  initial begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 12'h0;
    wdata = 64'h0;
    slow = 1'b0;
    sens = {4{8'h20}};
    ppw = 16'h0;
    rest = 16'h0;
    pc = TPL_PKG_CFG_RST;
    pl = TPL_PLAT_CFG_RST;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_reset;
    t_regs;
    t_sensor_max;
    t_offset;
    t_power;
    wrap_up;
  end
endmodule

// >>> dv/tpl_reg_model.sv
`timescale 1ns/1ps
module tpl_reg_model (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // Platform loads
  input  wire logic        i_slow,
  input  wire logic [15:0] i_cpu_pw,
  input  wire logic [15:0] i_rest_pw,
  // Telemetry
  output logic      [15:0] o_plat_power
);
  logic [2:0] div_r;
  // A slow regulator refreshes telemetry only every eighth cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      div_r        <= 3'h0;
      o_plat_power <= 16'h0000;
    end else begin
      div_r <= div_r + 3'h1;
      if (!i_slow || div_r == 3'h0) begin
        // Battery charging power never enters the total.
        o_plat_power <= i_cpu_pw + i_rest_pw;
      end
    end
  end
endmodule

// >>> dv/tpl_thermal_power_ctl_sva.sv
`timescale 1ns/1ps
module tpl_thermal_power_ctl_sva #(
  parameter logic [7:0] P_MAX_JUNCTION_TEMP = 8'h64
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [11:0] i_reg_addr,
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_wr,
  input  wire logic [63:0] o_reg_rdata,
  input  wire logic        o_reg_ack,
  // Sensors and control
  input  wire logic [tpl_pkg::TPL_NUM_SENSORS-1:0][7:0] i_on_die_temp_sensor,
  input  wire logic [7:0]  o_core_ratio,
  input  wire logic [7:0]  o_gfx_ratio,
  input  wire logic        o_thermal_control_circuit,
  input  wire logic        o_processor_hot_pin,
  input  wire logic        o_power_limited
);
  import tpl_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic       any_max;
  logic [6:0] hot_cnt_r;
  always_comb begin
    any_max = 1'b0;
    for (int i = 0; i < TPL_NUM_SENSORS; i++) begin
      if (i_on_die_temp_sensor[i] == 8'h00) begin
        any_max = 1'b1;
      end
    end
  end
  // Sample ticks are 40 cycles apart, so 44 cycles at the maximum is enough.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn || !any_max) begin
      hot_cnt_r <= 7'h00;
    end else if (hot_cnt_r != 7'h7f) begin
      hot_cnt_r <= hot_cnt_r + 7'h01;
    end
  end
  chk_ack_after_req: assert property (
    (i_reg_rd || i_reg_wr) |=> o_reg_ack)
    else $error("register ack missing");
  chk_ack_has_cause: assert property (
    o_reg_ack |-> $past(i_reg_rd || i_reg_wr))
    else $error("register ack without request");
  chk_rdata_idle: assert property (!o_reg_ack |-> o_reg_rdata == 64'h0)
    else $error("read data not zero while idle");
  chk_tmax_read: assert property (o_reg_ack && $past(i_reg_rd &&
    i_reg_addr == 12'h1a2) |-> o_reg_rdata[23:16] == P_MAX_JUNCTION_TEMP &&
    o_reg_rdata[63:30] == 34'h0 && o_reg_rdata[15:7] == 9'h0)
    else $error("max temperature field wrong");
  chk_hot_follows: assert property (1'b1 |=>
    o_processor_hot_pin == $past(o_thermal_control_circuit))
    else $error("hot pin does not follow control");
  chk_ratio_floor: assert property (
    o_core_ratio >= 8'h08 && o_gfx_ratio >= 8'h08)
    else $error("ratio below floor");
  chk_tcc_lowers: assert property ($past(o_thermal_control_circuit) &&
    o_thermal_control_circuit && ($changed(o_core_ratio) ||
    $changed(o_gfx_ratio)) |-> o_core_ratio <= $past(o_core_ratio) &&
    o_gfx_ratio <= $past(o_gfx_ratio))
    else $error("ratio rose while control active");
  chk_max_act: assert property (
    hot_cnt_r == 7'h2c |-> o_thermal_control_circuit)
    else $error("no activation at max temperature");
  chk_flag_hold: assert property (
    $changed(o_thermal_control_circuit) |=>
    $stable(o_thermal_control_circuit)[*8])
    else $error("control flag changed between ticks");
  cov_tcc_on: cover property ($rose(o_thermal_control_circuit));
  cov_limited: cover property ($rose(o_power_limited));
  cov_wr_ack: cover property (i_reg_wr ##1 o_reg_ack);
endmodule

bind tpl_thermal_power_ctl tpl_thermal_power_ctl_sva #(
  .P_MAX_JUNCTION_TEMP(P_MAX_JUNCTION_TEMP)
) i_sva (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
  .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .o_reg_rdata(o_reg_rdata),
  .o_reg_ack(o_reg_ack), .i_on_die_temp_sensor(i_on_die_temp_sensor),
  .o_core_ratio(o_core_ratio), .o_gfx_ratio(o_gfx_ratio),
  .o_thermal_control_circuit(o_thermal_control_circuit),
  .o_processor_hot_pin(o_processor_hot_pin),
  .o_power_limited(o_power_limited));

// >>> include/tpl_pkg.sv
package tpl_pkg;

  localparam int unsigned TPL_NUM_SENSORS = 4;
  localparam int unsigned TPL_CLK_PERIOD_NS = 25;
  localparam int unsigned TPL_SAMPLE_NS = 1000;
  localparam int unsigned TPL_SAMPLE_CYC =
    (TPL_SAMPLE_NS + TPL_CLK_PERIOD_NS - 1) / TPL_CLK_PERIOD_NS;

  localparam logic [11:0] TPL_THERM_TARGET_ADDR = 12'h1a2;
  localparam int unsigned TPL_MAX_JUNCTION_TEMP_LSB = 16;
  localparam int unsigned TPL_MAX_JUNCTION_TEMP_MSB = 23;
  localparam int unsigned TPL_OFS_LSB = 24;
  localparam int unsigned TPL_OFS_MSB = 29;
  localparam int unsigned TPL_TAU_LSB = 0;
  localparam int unsigned TPL_TAU_MSB = 6;
  localparam logic [5:0] TPL_OFS_RST = 6'h00;
  localparam logic [6:0] TPL_TAU_RST = 7'h00;
  localparam logic [7:0] TPL_MAX_JUNCTION_TEMP_DEFAULT = 8'h64;

  localparam logic [7:0] TPL_MIN_RATIO = 8'h08;
  localparam logic [7:0] TPL_RATIO_RST = 8'h08;
  localparam logic [7:0] TPL_RAPID_STEP = 8'h04;
  localparam logic [7:0] TPL_SLOW_STEP = 8'h01;
  localparam logic [3:0] TPL_MAX_SHIFT = 4'hf;
  localparam int unsigned TPL_WEIGHTED_MOVING_AVERAGE_FRAC = 8;
  localparam int unsigned TPL_CEIL_GUARD_SHIFT = 3;

  typedef enum logic [2:0] {
    TPL_ST_NORMAL  = 3'b001,
    TPL_ST_LIMIT   = 3'b010,
    TPL_ST_RESTORE = 3'b100
  } tpl_state_t;

  typedef struct packed {
    logic [15:0] sustained_power_cap;
    logic [15:0] burst_power_cap;
    logic [15:0] spike_duty_power_cap;
    logic [15:0] absolute_power_ceiling;
    logic        spike_duty_en;
    logic [3:0]  tau_shift;
  } tpl_pkg_cfg_t;

  typedef struct packed {
    logic        plat_en;
    logic [15:0] platform_sustained_cap;
    logic [15:0] platform_burst_cap;
    logic [15:0] platform_spike_duty_cap;
    logic        spike_duty_en;
    logic [3:0]  tau_shift;
  } tpl_plat_cfg_t;

  localparam tpl_pkg_cfg_t TPL_PKG_CFG_RST = '0;
  localparam tpl_plat_cfg_t TPL_PLAT_CFG_RST = '0;

endpackage

// >>> src/tpl_thermal_power_ctl.sv
`timescale 1ns/1ps
module tpl_thermal_power_ctl #(
  parameter logic [7:0] P_MAX_JUNCTION_TEMP = tpl_pkg::TPL_MAX_JUNCTION_TEMP_DEFAULT
) (
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rstn,
  // Thermal target register port
  input  wire logic [11:0]               i_reg_addr,
  input  wire logic                      i_reg_rd,
  input  wire logic                      i_reg_wr,
  input  wire logic [63:0]               i_reg_wdata,
  output logic      [63:0]               o_reg_rdata,
  output logic                           o_reg_ack,
  // On-die sensors, distance below maximum temperature
  input  wire logic [tpl_pkg::TPL_NUM_SENSORS-1:0][7:0] i_on_die_temp_sensor,
  // Power telemetry
  input  wire logic [15:0]               i_pkg_power,
  input  wire logic [15:0]               i_plat_power,
  // Power limit configuration
  input  wire tpl_pkg::tpl_pkg_cfg_t     i_pkg_cfg,
  input  wire tpl_pkg::tpl_plat_cfg_t    i_plat_cfg,
  // Ratio ceilings
  input  wire logic [7:0]                i_max_core_ratio,
  input  wire logic [7:0]                i_max_gfx_ratio,
  // Control outputs
  output logic      [7:0]                o_core_ratio,
  output logic      [7:0]                o_gfx_ratio,
  output logic                           o_thermal_control_circuit,
  output logic                           o_processor_hot_pin,
  output logic                           o_power_limited
);
  import tpl_pkg::*;

  function automatic logic [7:0] tpl_min8(input logic [7:0] a,
                                          input logic [7:0] b);
    tpl_min8 = (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] tpl_step_down(input logic [7:0] r,
                                               input logic [7:0] s);
    tpl_step_down = (r > TPL_MIN_RATIO + s) ? r - s : TPL_MIN_RATIO;
  endfunction

  function automatic logic [7:0] tpl_step_up(input logic [7:0] r,
                                             input logic [7:0] mx);
    if (r > mx) begin
      tpl_step_up = mx;
    end else if (r < mx) begin
      tpl_step_up = r + TPL_SLOW_STEP;
    end else begin
      tpl_step_up = r;
    end
  endfunction

  function automatic logic [16:0] tpl_guard(input logic [15:0] p);
    tpl_guard = {1'b0, p} + {4'h0, p[15:TPL_CEIL_GUARD_SHIFT]};
  endfunction

  // Sample timing.
  logic [5:0]    tick_cnt_r;
  logic          tick_r;

  // Thermal target register fields.
  logic [5:0]    offset_r;
  logic [6:0]    tau_r;
  logic [63:0]   rdata_r;
  logic          ack_r;

  // Captured configuration; optional caps come out of reset disabled.
  tpl_pkg_cfg_t  pkg_cfg_r;
  tpl_plat_cfg_t plat_cfg_r;

  // Temperature path.
  logic [7:0]    hot_chain [TPL_NUM_SENSORS:0];
  logic [7:0]    hottest_r;
  logic [7:0]    inst_temp;
  logic [7:0]    set_point;
  logic [3:0]    temp_shift;
  logic [15:0]   avg_temp_w;
  logic [15:0]   pkg_avg;
  logic [15:0]   plat_avg;

  // Limit decisions.
  logic          at_max;
  logic          over_set;
  logic          tcc_nxt;
  logic          tcc_r;
  logic          slow_lim;
  logic          rapid_lim;
  logic          pwr_lim_r;
  tpl_state_t    state_r;
  tpl_state_t    state_nxt;
  logic [7:0]    core_ratio_r;
  logic [7:0]    gfx_ratio_r;
  logic          hot_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      tick_cnt_r <= 6'h00;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 6'(TPL_SAMPLE_CYC - 1)) begin
      tick_cnt_r <= 6'h00;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 6'h01;
      tick_r     <= 1'b0;
    end
  end

  // Only offset and window are writable; the maximum temperature field
  // is a constant and there is no enable bit for the protection.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      offset_r <= TPL_OFS_RST;
      tau_r    <= TPL_TAU_RST;
    end else if (i_reg_wr && i_reg_addr == TPL_THERM_TARGET_ADDR) begin
      offset_r <= i_reg_wdata[TPL_OFS_MSB:TPL_OFS_LSB];
      tau_r    <= i_reg_wdata[TPL_TAU_MSB:TPL_TAU_LSB];
    end
  end

  // Every access is answered the next cycle; other addresses read zero.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rdata_r <= 64'h0000000000000000;
      ack_r   <= 1'b0;
    end else begin
      ack_r   <= i_reg_rd | i_reg_wr;
      rdata_r <= 64'h0000000000000000;
      if (i_reg_rd && i_reg_addr == TPL_THERM_TARGET_ADDR) begin
        rdata_r[TPL_MAX_JUNCTION_TEMP_MSB:TPL_MAX_JUNCTION_TEMP_LSB] <= P_MAX_JUNCTION_TEMP;
        rdata_r[TPL_OFS_MSB:TPL_OFS_LSB]     <= offset_r;
        rdata_r[TPL_TAU_MSB:TPL_TAU_LSB]     <= tau_r;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      pkg_cfg_r  <= TPL_PKG_CFG_RST;
      plat_cfg_r <= TPL_PLAT_CFG_RST;
    end else begin
      pkg_cfg_r  <= i_pkg_cfg;
      plat_cfg_r <= i_plat_cfg;
    end
  end

  // The hottest sensor is the one closest to the maximum.
  assign hot_chain[0] = 8'hff;
  genvar g;
  generate
    for (g = 0; g < TPL_NUM_SENSORS; g++) begin : g_hot
      assign hot_chain[g+1] = tpl_min8(hot_chain[g],
                                       i_on_die_temp_sensor[g]);
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      hottest_r <= 8'hff;
    end else begin
      hottest_r <= hot_chain[TPL_NUM_SENSORS];
    end
  end

  // Readings never exceed the maximum, so a larger distance than the
  // maximum simply clamps the absolute temperature at zero.
  always_comb begin
    inst_temp = (hottest_r > P_MAX_JUNCTION_TEMP) ? 8'h00
              : P_MAX_JUNCTION_TEMP - hottest_r;
    set_point = ({2'b00, offset_r} > P_MAX_JUNCTION_TEMP) ? 8'h00
              : P_MAX_JUNCTION_TEMP - {2'b00, offset_r};
    temp_shift = (tau_r > {3'h0, TPL_MAX_SHIFT}) ? TPL_MAX_SHIFT
               : tau_r[3:0];
  end

  tpl_weighted_moving_average u_temp_avg (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_sample   (tick_r),
    .i_value    ({8'h00, inst_temp}),
    .i_shift    (temp_shift),
    .o_avg      (avg_temp_w)
  );

  tpl_weighted_moving_average u_pkg_avg (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_sample   (tick_r),
    .i_value    (i_pkg_power),
    .i_shift    (pkg_cfg_r.tau_shift),
    .o_avg      (pkg_avg)
  );

  tpl_weighted_moving_average u_plat_avg (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_sample   (tick_r),
    .i_value    (i_plat_power),
    .i_shift    (plat_cfg_r.tau_shift),
    .o_avg      (plat_avg)
  );

  always_comb begin
    at_max   = (hottest_r == 8'h00);
    if (tau_r == 7'h00) begin
      over_set = (inst_temp >= set_point);
    end else begin
      over_set = (avg_temp_w >= {8'h00, set_point});
    end
    tcc_nxt = at_max | over_set;
  end

  // Slow limits nudge the ratio; rapid ones cut it in larger steps.
  always_comb begin
    slow_lim  = (pkg_avg > pkg_cfg_r.sustained_power_cap);
    rapid_lim = (i_pkg_power > pkg_cfg_r.burst_power_cap)
              | (tpl_guard(i_pkg_power)
                 > {1'b0, pkg_cfg_r.absolute_power_ceiling})
              | at_max;
    if (pkg_cfg_r.spike_duty_en &&
        i_pkg_power > pkg_cfg_r.spike_duty_power_cap) begin
      rapid_lim = 1'b1;
    end
    if (plat_cfg_r.plat_en) begin
      if (plat_avg > plat_cfg_r.platform_sustained_cap) begin
        slow_lim = 1'b1;
      end
      if (i_plat_power > plat_cfg_r.platform_burst_cap) begin
        rapid_lim = 1'b1;
      end
      if (plat_cfg_r.spike_duty_en &&
          i_plat_power > plat_cfg_r.platform_spike_duty_cap) begin
        rapid_lim = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      tcc_r     <= 1'b0;
      pwr_lim_r <= 1'b0;
    end else if (tick_r) begin
      tcc_r     <= tcc_nxt;
      pwr_lim_r <= slow_lim | rapid_lim;
    end
  end

  always_comb begin
    if (tcc_r || pwr_lim_r) begin
      state_nxt = TPL_ST_LIMIT;
    end else if (core_ratio_r != i_max_core_ratio ||
                 gfx_ratio_r != i_max_gfx_ratio) begin
      state_nxt = TPL_ST_RESTORE;
    end else begin
      state_nxt = TPL_ST_NORMAL;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state_r <= TPL_ST_RESTORE;
    end else begin
      // Following every cycle lets the next tick step down at once.
      state_r <= state_nxt;
    end
  end

  // Both domains move together; while a limit stands the ratio keeps
  // falling each sample until the floor, so recovery waits for release.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      core_ratio_r <= TPL_RATIO_RST;
      gfx_ratio_r  <= TPL_RATIO_RST;
    end else if (tick_r) begin
      case (state_r)
        TPL_ST_LIMIT: begin
          if (rapid_lim) begin
            core_ratio_r <= tpl_step_down(core_ratio_r,
                                          TPL_RAPID_STEP);
            gfx_ratio_r  <= tpl_step_down(gfx_ratio_r,
                                          TPL_RAPID_STEP);
          end else if (tcc_r || pwr_lim_r) begin
            core_ratio_r <= tpl_step_down(core_ratio_r,
                                          TPL_SLOW_STEP);
            gfx_ratio_r  <= tpl_step_down(gfx_ratio_r,
                                          TPL_SLOW_STEP);
          end
        end
        TPL_ST_RESTORE: begin
          core_ratio_r <= tpl_step_up(core_ratio_r, i_max_core_ratio);
          gfx_ratio_r  <= tpl_step_up(gfx_ratio_r, i_max_gfx_ratio);
        end
        TPL_ST_NORMAL: begin
          core_ratio_r <= tpl_step_up(core_ratio_r, i_max_core_ratio);
          gfx_ratio_r  <= tpl_step_up(gfx_ratio_r, i_max_gfx_ratio);
        end
        default: begin
          core_ratio_r <= TPL_RATIO_RST;
          gfx_ratio_r  <= TPL_RATIO_RST;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      hot_r <= 1'b0;
    end else begin
      hot_r <= tcc_r;
    end
  end

  assign o_reg_rdata               = rdata_r;
  assign o_reg_ack                 = ack_r;
  assign o_core_ratio              = core_ratio_r;
  assign o_gfx_ratio               = gfx_ratio_r;
  assign o_thermal_control_circuit = tcc_r;
  assign o_processor_hot_pin       = hot_r;
  assign o_power_limited           = pwr_lim_r;

endmodule

// >>> src/tpl_weighted_moving_average.sv
`timescale 1ns/1ps
module tpl_weighted_moving_average (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // Sample stream
  input  wire logic        i_sample,
  input  wire logic [15:0] i_value,
  input  wire logic [3:0]  i_shift,
  // Average
  output logic      [15:0] o_avg
);
  import tpl_pkg::*;

  logic        [23:0] acc_r;
  logic signed [24:0] diff;
  logic signed [24:0] step;
  logic signed [24:0] sum;

  // A shift of zero makes the average follow the input at once.
  always_comb begin
    diff = $signed({1'b0, i_value, 8'h00}) - $signed({1'b0, acc_r});
    step = diff >>> i_shift;
    sum  = $signed({1'b0, acc_r}) + step;
  end

  // The accumulator is not restarted on a window change, so the
  // average settles toward new limits at the new window's pace.
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      acc_r <= 24'h000000;
    end else if (i_sample) begin
      acc_r <= sum[23:0];
    end
  end

  assign o_avg = acc_r[23:TPL_WEIGHTED_MOVING_AVERAGE_FRAC];

endmodule
